// *** src/rups_map.svh ***
// register map, field positions, reset values and timing counts of the power-state controller
`ifndef RUPS_MAP_SVH
`define RUPS_MAP_SVH

// ==========================================================
// clock and timebase
`define RUPS_CLK_NS 50
`define RUPS_MS_NS 1000000
`define RUPS_MS_CYC (`RUPS_MS_NS / `RUPS_CLK_NS)

// ==========================================================
// register byte offsets
`define RUPS_A_CTRL 8'h00
`define RUPS_A_CMD 8'h04
`define RUPS_A_WAKE_TO 8'h08
`define RUPS_A_SLEEP_TO 8'h0c
`define RUPS_A_STATUS 8'h10

// ==========================================================
// field positions
`define RUPS_F_MODE_LO 0
`define RUPS_F_BRIDGE 2
`define RUPS_F_TRAFFIC 3
`define RUPS_F_HSTBY 4
`define RUPS_F_FORCE 0
`define RUPS_F_SI 3
`define RUPS_F_SEC_LO 16

// ==========================================================
// reset values and limits, seconds
`define RUPS_WAKE_DEF 16'h012c
`define RUPS_WAKE_MIN 16'h003c
`define RUPS_WAKE_MAX 16'hfd20
`define RUPS_SLEEP_DEF 16'h000a

// ==========================================================
// times as printed, and their millisecond counts
`define RUPS_BOOT_S 48
`define RUPS_TO_SAVE_S 4
`define RUPS_ARM_S 2
`define RUPS_RELEASE_S 1
`define RUPS_BLINK_WIN_S 10
`define RUPS_BTN_S 1
`define RUPS_SEC_MS 1000
`define RUPS_BOOT_MS (`RUPS_BOOT_S * `RUPS_SEC_MS)
`define RUPS_TO_SAVE_MS (`RUPS_TO_SAVE_S * `RUPS_SEC_MS)
`define RUPS_ARM_MS (`RUPS_ARM_S * `RUPS_SEC_MS)
`define RUPS_RELEASE_MS (`RUPS_RELEASE_S * `RUPS_SEC_MS)
`define RUPS_BLINK_WIN_MS (`RUPS_BLINK_WIN_S * `RUPS_SEC_MS)
`define RUPS_BTN_MS (`RUPS_BTN_S * `RUPS_SEC_MS)
`define RUPS_BLINK_BIT 6

// ==========================================================
// bus responses
`define RUPS_RESP_OK 2'h0
`define RUPS_RESP_ERR 2'h2

`endif

// *** src/rups_pkg.sv ***
// types of the power-state controller
package rups_pkg;

  // ==========================================================
  // supply modes; code 3 is not a mode
  typedef enum logic [1:0] {
    MODE_ON = 2'h0,
    MODE_SAVE = 2'h1,
    MODE_SLEEP = 2'h2
  } rups_mode_t;

  // ==========================================================
  // power states
  typedef enum logic [2:0] {
    ST_ON = 3'h0,
    ST_ACTIVE = 3'h1,
    ST_TO_SAVE = 3'h2,
    ST_SAVE = 3'h3,
    ST_BOOT = 3'h4,
    ST_HWBOOT = 3'h5,
    ST_SLEEP_WAIT = 3'h6,
    ST_SLEEP = 3'h7
  } rups_state_t;

endpackage

// *** src/rups_tick.sv ***
// millisecond timebase pulse generator
`include "rups_map.svh"

module rups_tick #(
  parameter int unsigned MS_CYCLES = `RUPS_MS_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // one-cycle pulse per millisecond
  output logic ms_tick
);

  localparam int W = $clog2(MS_CYCLES);

  if (MS_CYCLES < 2) begin : g_chk
    $error("rups_tick: MS_CYCLES must be at least 2");
  end

  logic [W-1:0] cnt;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= '0;
      ms_tick <= 1'b0;
    end else if (ce) begin
      if (cnt == W'(MS_CYCLES - 1)) begin
        cnt <= '0;
        ms_tick <= 1'b1;
      end else begin
        cnt <= cnt + 1'b1;
        ms_tick <= 1'b0;
      end
    end
  end

endmodule

// *** src/rups_ctrl.sv ***
// power-state controller of a radio unit with an AXI4-Lite register slave
//
// Functional notes
// - three supply modes: always on (default, no saving), save, sleep
// - save mode has a listen-only low-power state and a fully active state
// - wake from low power boots for 48 s; entering low power takes 4 s
// - rising edge of sleep input wakes from low power; pulses above 50 ms
// - falling edge while active enters low power if input was high 2 s
// - qualifying radio packet wakes from low power; its payload is dropped
// - as bridge, every received radio packet qualifies
// - as router, only packets for own or routed addresses qualify
// - reboot while active stays active and restarts the wake timeout
// - reboot while in low power re-enters low power after the reboot
// - save-mode configuration change while active restarts the wake timeout
// - wake timeout in seconds, default 300, 60..64800; expiry enters low power
// - a command forces low power at any moment; the code acts on it only in the active state
// - optional: radio traffic while active restarts the wake timeout
// - boot after reboot in low power blinks 10 s; 1 s button forces always on
// - sleep mode: grounded sleep input sleeps; waking boots for 48 s
// - sleep entered after a sleep-request timeout, seconds, default 10
// - sleep input released 1 s during that timeout restarts it
// - with hot standby on, save and sleep modes cannot be selected
//
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`include "rups_map.svh"

module rups_ctrl
  import rups_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `RUPS_MS_CYC
) (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // pins
  input wire logic si_pin,
  input wire logic btn_n_pin,
  // radio and system events, same clock
  input wire logic rx_pkt,
  input wire logic rx_dest_hit,
  input wire logic tx_pkt,
  input wire logic reboot_evt,
  // power outputs
  output logic [2:0] power_state,
  output logic led_fast_blink,
  output logic rx_drop
);

  localparam logic [16:0] BOOT_MS = 17'(`RUPS_BOOT_MS);
  localparam logic [16:0] TO_SAVE_MS = 17'(`RUPS_TO_SAVE_MS);
  localparam logic [16:0] BLINK_WIN_MS = 17'(`RUPS_BLINK_WIN_MS);
  localparam logic [16:0] SEC_MS = 17'(`RUPS_SEC_MS);
  localparam logic [10:0] ARM_MS = 11'(`RUPS_ARM_MS);
  localparam logic [10:0] RELEASE_MS = 11'(`RUPS_RELEASE_MS);
  localparam logic [10:0] BTN_MS = 11'(`RUPS_BTN_MS);

  // ==========================================================
  // helpers
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic [15:0] clamp_wake(input logic [15:0] v);
    if (v < `RUPS_WAKE_MIN) clamp_wake = `RUPS_WAKE_MIN;
    else if (v > `RUPS_WAKE_MAX) clamp_wake = `RUPS_WAKE_MAX;
    else clamp_wake = v;
  endfunction

  // ==========================================================
  // declarations
  rups_state_t state, next_state;
  rups_mode_t mode;
  logic ms_tick;
  logic si_s1, si_s2, si_d, btn_s1, btn_s2;
  logic si_rise, si_fall;
  logic [10:0] hi_ms, btn_ms;
  logic [16:0] tmr_ms;
  logic [15:0] sec_cnt;
  logic bridge, traffic, hstby, force_pls;
  logic [15:0] wake_to, sleep_to;
  logic aw_got, w_got;
  logic [7:0] waddr;
  logic [31:0] wdat;
  logic [3:0] wstb;
  logic do_wr, wr_ctrl, wr_cmd, wr_wake, wr_sleep, cfg_touch;
  logic fall_ok, rx_hit, wake_exp, btn_force, restart, tmr_clr;

  // ==========================================================
  // timebase
  rups_tick #(.MS_CYCLES(MS_CYCLES)) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .ms_tick(ms_tick)
  );

  // ==========================================================
  // pin synchronisers; the first stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // reset to the open level of the pin so that no false edge follows reset
      si_s1 <= 1'b1;
      si_s2 <= 1'b1;
      si_d <= 1'b1;
      btn_s1 <= 1'b1;
      btn_s2 <= 1'b1;
    end else if (ce) begin
      si_s1 <= si_pin;
      si_s2 <= si_s1;
      si_d <= si_s2;
      btn_s1 <= btn_n_pin;
      btn_s2 <= btn_s1;
    end
  end

  assign si_rise = si_s2 && !si_d;
  assign si_fall = !si_s2 && si_d;

  // ==========================================================
  // level durations in milliseconds, saturating
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hi_ms <= '0;
    end else if (ce) begin
      // only high time spent while active or waiting to sleep counts
      if (!si_s2 || !(state inside {ST_ACTIVE, ST_SLEEP_WAIT})) begin
        hi_ms <= '0;
      end else if (ms_tick && hi_ms != ARM_MS) begin
        hi_ms <= hi_ms + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      btn_ms <= '0;
    end else if (ce) begin
      if (btn_s2) begin
        btn_ms <= '0;
      end else if (ms_tick && btn_ms != BTN_MS) begin
        btn_ms <= btn_ms + 1'b1;
      end
    end
  end

  // ==========================================================
  // axi4-lite write channels, taken in either order
  assign do_wr = aw_got && w_got && !bvalid;
  assign wr_ctrl = do_wr && waddr == `RUPS_A_CTRL;
  assign wr_cmd = do_wr && waddr == `RUPS_A_CMD;
  assign wr_wake = do_wr && waddr == `RUPS_A_WAKE_TO;
  assign wr_sleep = do_wr && waddr == `RUPS_A_SLEEP_TO;
  assign cfg_touch = wr_ctrl || wr_wake || wr_sleep;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      aw_got <= 1'b0;
      waddr <= 8'h00;
    end else if (ce) begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        aw_got <= 1'b1;
        waddr <= awaddr;
      end else if (!aw_got && !bvalid && !awready) begin
        awready <= 1'b1;
      end
      if (do_wr) begin
        aw_got <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready <= 1'b0;
      w_got <= 1'b0;
      wdat <= 32'h00000000;
      wstb <= 4'h0;
    end else if (ce) begin
      if (wvalid && wready) begin
        wready <= 1'b0;
        w_got <= 1'b1;
        wdat <= wdata;
        wstb <= wstrb;
      end else if (!w_got && !bvalid && !wready) begin
        wready <= 1'b1;
      end
      if (do_wr) begin
        w_got <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `RUPS_RESP_OK;
    end else if (ce) begin
      if (do_wr) begin
        bvalid <= 1'b1;
        bresp <= (cfg_touch || wr_cmd || waddr == `RUPS_A_STATUS) ? `RUPS_RESP_OK : `RUPS_RESP_ERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // axi4-lite read, answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `RUPS_RESP_OK;
    end else if (ce) begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rresp <= `RUPS_RESP_OK;
        unique case (araddr)
          `RUPS_A_CTRL: rdata <= {27'h0, hstby, traffic, bridge, mode};
          `RUPS_A_CMD: rdata <= 32'h00000000;
          `RUPS_A_WAKE_TO: rdata <= {16'h0000, wake_to};
          `RUPS_A_SLEEP_TO: rdata <= {16'h0000, sleep_to};
          `RUPS_A_STATUS: rdata <= {sec_cnt, 12'h000, si_s2, state};
          default: begin
            rdata <= 32'h00000000;
            rresp <= `RUPS_RESP_ERR;
          end
        endcase
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end else if (!rvalid && !arready) begin
        arready <= 1'b1;
      end
    end
  end

  // ==========================================================
  // configuration registers
  assign btn_force = state == ST_HWBOOT && btn_ms == BTN_MS;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode <= MODE_ON;
      bridge <= 1'b0;
      traffic <= 1'b0;
      hstby <= 1'b0;
      wake_to <= `RUPS_WAKE_DEF;
      sleep_to <= `RUPS_SLEEP_DEF;
      force_pls <= 1'b0;
    end else if (ce) begin
      force_pls <= wr_cmd && wstb[0] && wdat[`RUPS_F_FORCE];
      if (wr_ctrl && wstb[0]) begin
        bridge <= wdat[`RUPS_F_BRIDGE];
        traffic <= wdat[`RUPS_F_TRAFFIC];
        hstby <= wdat[`RUPS_F_HSTBY];
        // a reserved mode code leaves the mode unchanged
        if (wdat[`RUPS_F_HSTBY]) begin
          mode <= MODE_ON;
        end else if (wdat[1:0] != 2'h3) begin
          mode <= rups_mode_t'(wdat[1:0]);
        end
      end
      if (btn_force) begin
        mode <= MODE_ON;
      end
      if (wr_wake) begin
        wake_to <= clamp_wake(merge16(wake_to, wdat, wstb));
      end
      if (wr_sleep) begin
        sleep_to <= merge16(sleep_to, wdat, wstb);
      end
    end
  end

  // ==========================================================
  // state machine
  assign rx_hit = rx_pkt && (bridge || rx_dest_hit);
  assign fall_ok = si_fall && hi_ms == ARM_MS;
  assign wake_exp = sec_cnt >= wake_to;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_ON: begin
        if (mode == MODE_SAVE) next_state = ST_ACTIVE;
        else if (mode == MODE_SLEEP && !si_s2) next_state = ST_SLEEP_WAIT;
      end
      ST_ACTIVE: begin
        // a reboot here keeps the state; the timer restart is done below
        if (mode != MODE_SAVE) next_state = ST_ON;
        else if (reboot_evt) next_state = ST_ACTIVE;
        else if (force_pls || fall_ok || wake_exp) next_state = ST_TO_SAVE;
      end
      ST_TO_SAVE: begin
        if (reboot_evt) next_state = ST_HWBOOT;
        else if (ms_tick && tmr_ms >= TO_SAVE_MS - 1'b1) next_state = ST_SAVE;
      end
      ST_SAVE: begin
        if (reboot_evt) next_state = ST_HWBOOT;
        else if (si_rise || rx_hit) next_state = ST_BOOT;
      end
      ST_BOOT: begin
        if (ms_tick && tmr_ms >= BOOT_MS - 1'b1) begin
          next_state = mode == MODE_SAVE ? ST_ACTIVE : ST_ON;
        end
      end
      ST_HWBOOT: begin
        if (btn_force) next_state = ST_ON;
        else if (ms_tick && tmr_ms >= BLINK_WIN_MS - 1'b1) next_state = ST_SAVE;
      end
      ST_SLEEP_WAIT: begin
        if (mode != MODE_SLEEP || hi_ms >= RELEASE_MS) next_state = ST_ON;
        else if (sec_cnt >= sleep_to) next_state = ST_SLEEP;
      end
      ST_SLEEP: begin
        if (si_s2) next_state = ST_BOOT;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_ON;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // ==========================================================
  // timers: milliseconds in the state, seconds where a timeout runs
  assign restart = state == ST_ACTIVE &&
                   (reboot_evt || cfg_touch || (traffic && (rx_pkt || tx_pkt)));
  assign tmr_clr = next_state != state || restart;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tmr_ms <= '0;
      sec_cnt <= '0;
    end else if (ce) begin
      if (tmr_clr) begin
        tmr_ms <= '0;
        sec_cnt <= '0;
      end else if (ms_tick) begin
        if (state inside {ST_ACTIVE, ST_SLEEP_WAIT} && tmr_ms == SEC_MS - 1'b1) begin
          tmr_ms <= '0;
          if (sec_cnt != 16'hffff) sec_cnt <= sec_cnt + 1'b1;
        end else if (tmr_ms != 17'h1ffff) begin
          tmr_ms <= tmr_ms + 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // registered outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_state <= ST_ON;
      led_fast_blink <= 1'b0;
      rx_drop <= 1'b0;
    end else if (ce) begin
      power_state <= next_state;
      led_fast_blink <= state == ST_HWBOOT && tmr_ms[`RUPS_BLINK_BIT];
      // the waking packet only wakes; its payload is never delivered
      rx_drop <= state == ST_SAVE && rx_hit && !reboot_evt;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_save_hit;
    state == ST_SAVE && ce && rx_hit && !reboot_evt;
  endsequence

  sequence s_woken;
    state == ST_BOOT && rx_drop;
  endsequence

  property p_radio_wake;
    s_save_hit |=> s_woken;
  endproperty
  a_radio_wake: assert property (p_radio_wake) else $error("radio wake failed");

  property p_router_filter;
    state == ST_SAVE && ce && rx_pkt && !bridge && !rx_dest_hit && !si_rise && !reboot_evt
      |=> state == ST_SAVE && !rx_drop;
  endproperty
  a_router_filter: assert property (p_router_filter) else $error("foreign packet woke");

  property p_rise_wake;
    state == ST_SAVE && ce && si_rise && !reboot_evt |=> state == ST_BOOT;
  endproperty
  a_rise_wake: assert property (p_rise_wake) else $error("rising edge did not wake");

  property p_fall_save;
    state == ST_ACTIVE && ce && mode == MODE_SAVE && !reboot_evt && fall_ok |=> state == ST_TO_SAVE;
  endproperty
  a_fall_save: assert property (p_fall_save) else $error("qualified fall ignored");

  property p_fall_short;
    state == ST_ACTIVE && ce && si_fall && hi_ms < ARM_MS && !force_pls && !wake_exp
      && mode == MODE_SAVE |=> state == ST_ACTIVE;
  endproperty
  a_fall_short: assert property (p_fall_short) else $error("short high took effect");

  property p_to_save_time;
    state == ST_TO_SAVE && ce && ms_tick && tmr_ms == TO_SAVE_MS - 1'b1 && !reboot_evt
      |=> state == ST_SAVE && power_state == ST_SAVE;
  endproperty
  a_to_save_time: assert property (p_to_save_time) else $error("save entry time wrong");

  property p_boot_time;
    state == ST_BOOT && ce && ms_tick && tmr_ms == BOOT_MS - 1'b1 |=> state inside {ST_ACTIVE, ST_ON};
  endproperty
  a_boot_time: assert property (p_boot_time) else $error("boot time wrong");

  property p_expire;
    state == ST_ACTIVE && ce && mode == MODE_SAVE && !reboot_evt && wake_exp |=> state == ST_TO_SAVE;
  endproperty
  a_expire: assert property (p_expire) else $error("wake timeout ignored");

  property p_cfg_restart;
    state == ST_ACTIVE && ce && cfg_touch && next_state == ST_ACTIVE |=> tmr_ms == 0 && sec_cnt == 0;
  endproperty
  a_cfg_restart: assert property (p_cfg_restart) else $error("timeout not restarted");

  property p_hstby;
    hstby |-> mode == MODE_ON;
  endproperty
  a_hstby: assert property (p_hstby) else $error("mode allowed under standby");

  property p_wake_range;
    wake_to >= `RUPS_WAKE_MIN && wake_to <= `RUPS_WAKE_MAX;
  endproperty
  a_wake_range: assert property (p_wake_range) else $error("wake timeout out of range");

endmodule

// *** verif/rups_si_contact.sv ***
// contact model that grounds or opens the sleep input pin
module rups_si_contact #(
  parameter int MIN_LOW = 4000,
  parameter int MIN_HIGH = 200
) (
  // clock
  input wire logic aclk,
  // request from the bench, high asks for ground
  input wire logic ground_req,
  // pin, high while open
  output logic si_pin
);
  timeunit 1ns;
  timeprecision 1ns;

  int hold = 0;

  initial si_pin = 1'b1;

  // ==========================================================
  // level holding
  // a new request waits until the previous level has been held long enough,
  // so the bench cannot produce pulses that the unit is not required to see
  always @(posedge aclk) begin
    if (hold > 0) begin
      hold <= hold - 1;
    end else if (ground_req === si_pin) begin
      si_pin <= ~ground_req;
      hold <= ground_req ? MIN_LOW : MIN_HIGH;
    end
  end
endmodule

// *** verif/rups_ctrl_test.sv ***
// self-checking bench of the power-state controller
`include "rups_map.svh"

module rups_ctrl_test
  import rups_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ms shortened to two clocks to keep the run short
  localparam int MS = 2;

  logic aclk = 0, aresetn = 0, ce = 1, btn_n_pin = 1, tx_pkt = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic si_pin, ground_req = 0, rx_pkt = 0, rx_dest_hit = 0, reboot_evt = 0;
  logic [2:0] power_state;
  logic led_fast_blink, rx_drop;
  int n_mismatch = 0, cmp_count = 0;
  logic [33:0] exp_q[$];
  logic [1:0] bexp_q[$];
  logic [31:0] seed = 32'ha6c8;

  rups_ctrl #(.MS_CYCLES(MS)) rups_ctrl_inst (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .si_pin(si_pin), .btn_n_pin(btn_n_pin),
    .rx_pkt(rx_pkt), .rx_dest_hit(rx_dest_hit), .tx_pkt(tx_pkt), .reboot_evt(reboot_evt),
    .power_state(power_state), .led_fast_blink(led_fast_blink), .rx_drop(rx_drop)
  );

  rups_si_contact #(.MIN_LOW(2020 * MS), .MIN_HIGH(60 * MS)) rups_si_contact_inst (
    .aclk(aclk), .ground_req(ground_req), .si_pin(si_pin)
  );

  initial begin
    forever #25 aclk = ~aclk;
  end

  // ==========================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [15:0] clamp(input logic [15:0] v);
    return v < `RUPS_WAKE_MIN ? `RUPS_WAKE_MIN : (v > `RUPS_WAKE_MAX ? `RUPS_WAKE_MAX : v);
  endfunction

  task automatic check(input string name, input logic [33:0] seen, input logic [33:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic do_reset;
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
  endtask

  // ==========================================================
  // bus cycles; each channel is released only at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = `RUPS_RESP_OK);
    bit aw, w;
    bexp_q.push_back(r);
    aw = 0;
    w = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && awready) begin
        aw = 1;
        awvalid <= 0;
      end
      if (!w && wready) begin
        w = 1;
        wvalid <= 0;
      end
    end
    bready <= 1;
    do @(posedge aclk); while (!bvalid);
    bready <= 0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
    rready <= 0;
    // one edge between reads, so rready is never driven twice in a time step
    @(posedge aclk);
  endtask

  always @(posedge aclk) begin
    if (rvalid && rready) begin
      check("rresp_rdata", {rresp, rdata}, exp_q.pop_front());
    end
    if (bvalid && bready) begin
      check("bresp", 34'(bresp), 34'(bexp_q.pop_front()));
    end
  end

  task automatic wait_st(input rups_state_t s);
    int n;
    n = 0;
    while (power_state !== s && n < 30000) begin
      @(posedge aclk);
      n++;
    end
    check("state", 34'(power_state), 34'(s));
  endtask

  task automatic pkt(input logic hit);
    rx_dest_hit <= hit;
    rx_pkt <= 1;
    @(posedge aclk);
    rx_pkt <= 0;
    @(posedge aclk);
  endtask

  // ==========================================================
  // scenarios
  initial begin
    logic [15:0] v;
    do_reset;
    check("state", 34'(power_state), 34'(ST_ON));
    rd(`RUPS_A_CTRL, 34'h0);
    rd(`RUPS_A_WAKE_TO, 34'(`RUPS_WAKE_DEF));
    rd(`RUPS_A_SLEEP_TO, 34'(`RUPS_SLEEP_DEF));
    rd(8'h14, {`RUPS_RESP_ERR, 32'h0});
    wr(8'h14, 32'h0, `RUPS_RESP_ERR);
    for (int i = 0; i < 5; i++) begin
      seed = xs(seed);
      v = (i == 0) ? 16'h003b : seed[15:0];
      wr(`RUPS_A_WAKE_TO, {16'h0, v});
      rd(`RUPS_A_WAKE_TO, {18'h0, clamp(v)});
    end
    wr(`RUPS_A_CTRL, 32'h11);
    rd(`RUPS_A_CTRL, 34'h10);
    do_reset;
    // save mode with restart on radio traffic
    wr(`RUPS_A_CTRL, 32'h9);
    wait_st(ST_ACTIVE);
    // grounding before the input was high long enough must be ignored
    ground_req <= 1;
    repeat (200) @(posedge aclk);
    check("state", 34'(power_state), 34'(ST_ACTIVE));
    ground_req <= 0;
    repeat (2100 * MS) @(posedge aclk);
    // a sent packet restarts the running timeout: seconds read back as zero
    tx_pkt <= 1;
    @(posedge aclk);
    tx_pkt <= 0;
    rd(`RUPS_A_STATUS, 34'h9);
    wr(`RUPS_A_CMD, 32'h1);
    wait_st(ST_TO_SAVE);
    repeat (`RUPS_TO_SAVE_MS * MS - 10) @(posedge aclk);
    check("state", 34'(power_state), 34'(ST_TO_SAVE));
    repeat (20) @(posedge aclk);
    check("state", 34'(power_state), 34'(ST_SAVE));
    pkt(1'b0);
    check("state", 34'(power_state), 34'(ST_SAVE));
    reboot_evt <= 1;
    @(posedge aclk);
    reboot_evt <= 0;
    wait_st(ST_HWBOOT);
    repeat (96 * MS) @(posedge aclk);
    check("led_fast_blink", 34'(led_fast_blink), 34'h1);
    repeat (64 * MS) @(posedge aclk);
    check("led_fast_blink", 34'(led_fast_blink), 34'h0);
    repeat (`RUPS_BLINK_WIN_MS * MS - 10 - 160 * MS) @(posedge aclk);
    check("state", 34'(power_state), 34'(ST_HWBOOT));
    wait_st(ST_SAVE);
    pkt(1'b1);
    check("rx_drop", 34'(rx_drop), 34'h1);
    check("state", 34'(power_state), 34'(ST_BOOT));
    do_reset;
    wr(`RUPS_A_SLEEP_TO, 32'h1);
    wr(`RUPS_A_CTRL, 32'h2);
    ground_req <= 1;
    wait_st(ST_SLEEP_WAIT);
    repeat (`RUPS_SEC_MS * MS / 2) @(posedge aclk);
    check("state", 34'(power_state), 34'(ST_SLEEP_WAIT));
    wait_st(ST_SLEEP);
    print_verdict;
  end

  // a hang ends the run through the same verdict
  initial begin
    repeat (80000) @(posedge aclk);
    n_mismatch++;
    print_verdict;
  end
endmodule
